// File: fiap_pkg.sv
// Package with register map, field positions, codes and timing for the flash IAP control block.
package fiap_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [5:0] FIAP_OFF_OP_CTRL  = 6'h00;
  localparam logic [5:0] FIAP_OFF_AUX_CTRL = 6'h04;
  localparam logic [5:0] FIAP_OFF_DATA0    = 6'h08;
  localparam logic [5:0] FIAP_OFF_IRQ_STAT = 6'h20;
  localparam logic [5:0] FIAP_OFF_IRQ_MASK = 6'h24;
  localparam int         FIAP_DATA_REGS    = 6;

  // Operation control field positions.
  localparam int FIAP_UNLOCKED_BIT  = 7;
  localparam int FIAP_MODE_LSB      = 4;
  localparam int FIAP_TRIGGER_BIT   = 3;
  localparam int FIAP_PROG_BIT      = 2;
  localparam int FIAP_PERMIT_BIT    = 1;
  localparam int FIAP_READ_BIT      = 0;

  // Auxiliary control field positions.
  localparam int FIAP_AUX_R7_BIT    = 7;
  localparam int FIAP_AUX_R4_BIT    = 4;
  localparam int FIAP_AUX_CLEAR_BIT = 0;

  // Operation select codes.
  localparam logic [2:0] FIAP_MODE_WRITE  = 3'h0;
  localparam logic [2:0] FIAP_MODE_ERASE  = 3'h1;
  localparam logic [2:0] FIAP_MODE_READ   = 3'h3;
  localparam logic [2:0] FIAP_MODE_UNLOCK = 3'h6;

  // Key bytes in register order: second to fourth low, then second to fourth high.
  localparam logic [7:0] FIAP_KEY [FIAP_DATA_REGS] = '{8'h00, 8'h0d, 8'hc3, 8'h04, 8'h09, 8'h40};

  // Interrupt status bit positions.
  localparam int FIAP_IRQ_UNLOCK_OK   = 0;
  localparam int FIAP_IRQ_UNLOCK_FAIL = 1;
  localparam int FIAP_IRQ_PROG_DONE   = 2;
  localparam int FIAP_IRQ_READ_DONE   = 3;
  localparam int FIAP_IRQ_CLEAR_DONE  = 4;
  localparam int FIAP_IRQ_W           = 5;

  // Default process lengths in core clock cycles.
  localparam int unsigned FIAP_UNLOCK_CYCLES = 256;
  localparam int unsigned FIAP_PROG_CYCLES   = 64;
  localparam int unsigned FIAP_READ_CYCLES   = 4;
  localparam int unsigned FIAP_CLEAR_CYCLES  = 64;
  localparam int          FIAP_CNT_W         = 20;

  // Launch strobes and mode toward the flash array sequencer.
  typedef struct packed {
    logic       write_go;
    logic       erase_go;
    logic       read_go;
    logic       clear_go;
    logic [2:0] mode;
  } fiap_flash_type;

endpackage : fiap_pkg

// File: fiap_ctrl.sv
// Flash IAP control and data registers with unlock sequencer and process engine.
// Operation
// [R1] Unlocked flag set by hardware only; zero disables
// [R2] Mode codes: write, erase, read, unlock
// [R3] Software unlocks before erase or write
// [R4] Trigger starts timer; timer expiry clears trigger
// [R5] Software writes key quickly after trigger
// [R6] Six key bytes must match to unlock
// [R7] Wrong key leaves erase and write disabled
// [R8] Program start launches write, cleared when done
// [R9] CPU stalled while program or read runs
// [R10] Reads run only while read permit set
// [R11] Read start launches read, cleared when done
// [R12] Software never sets three start bits together
// [R13] Buffer clear bit cleared when clear completes
// [R14] Aux reserved bits kept zero or read zero
// [R15] Data word registers read/write, reset zero
// [R16] Parameterised unlock timer, compare while trigger set
module fiap_ctrl
  import fiap_pkg::*;
#(
  parameter int unsigned UNLOCK_CYCLES = FIAP_UNLOCK_CYCLES,
  parameter int unsigned PROG_CYCLES   = FIAP_PROG_CYCLES,
  parameter int unsigned READ_CYCLES   = FIAP_READ_CYCLES,
  parameter int unsigned CLEAR_CYCLES  = FIAP_CLEAR_CYCLES
) (
  // Clock and reset
  input  wire logic           core_clk,
  input  wire logic           nrst,
  // Avalon-MM slave
  input  wire logic [5:0]     avs_address,
  input  wire logic           avs_read,
  input  wire logic           avs_write,
  input  wire logic [31:0]    avs_writedata,
  output logic      [31:0]    avs_readdata,
  output logic                avs_waitrequest,
  // Flash array side
  output fiap_flash_type      flash_cmd,
  output logic                erase_write_unlocked,
  output logic                cpu_stall,
  // Interrupt
  output logic                irq
);

  typedef enum logic [1:0] {ENG_IDLE, ENG_PROG, ENG_READ, ENG_CLEAR} fiap_eng_type;

  fiap_eng_type                eng_ff;
  fiap_eng_type                nxt_eng;
  logic [FIAP_CNT_W-1:0]       eng_cnt_ff;
  logic [FIAP_CNT_W-1:0]       unl_cnt_ff;
  logic [2:0]                  mode_ff;
  logic                        unlocked_ff;
  logic                        trigger_ff;
  logic                        permit_ff;
  logic                        aux_r7_ff;
  logic                        aux_r4_ff;
  logic [7:0]                  data_ff [FIAP_DATA_REGS];
  logic [FIAP_DATA_REGS-1:0]   written_ff;
  logic [FIAP_IRQ_W-1:0]       irq_stat_ff;
  logic [FIAP_IRQ_W-1:0]       irq_mask_ff;
  logic                        rd_done_ff;
  logic [31:0]                 readdata_ff;
  fiap_flash_type              flash_cmd_ff;

  logic                        wr_op;
  logic                        wr_aux;
  logic                        rd_first;
  logic                        rd_stat_done;
  logic                        key_ok;
  logic                        unlock_hit;
  logic                        trig_expire;
  logic                        start_prog;
  logic                        start_read;
  logic                        start_clear;
  logic                        eng_end;
  logic [3:0]                  word_idx;
  logic [7:0]                  op_view;
  logic [7:0]                  aux_view;
  logic [FIAP_IRQ_W-1:0]       irq_events;

  // Decode. Writes finish in the cycle they appear; reads take one extra cycle.
  assign word_idx     = avs_address[5:2];
  assign wr_op        = avs_write && (word_idx == FIAP_OFF_OP_CTRL[5:2]);
  assign wr_aux       = avs_write && (word_idx == FIAP_OFF_AUX_CTRL[5:2]);
  assign rd_first     = avs_read && !rd_done_ff;
  assign rd_stat_done = avs_read && rd_done_ff && (word_idx == FIAP_OFF_IRQ_STAT[5:2]);
  assign avs_waitrequest = rd_first;
  assign avs_readdata    = readdata_ff;

  // The key counts only if every byte was written after the trigger rose.
  always_comb begin
    key_ok = &written_ff; // R16
    for (int i = 0; i < FIAP_DATA_REGS; i++) begin
      if (data_ff[i] != FIAP_KEY[i]) begin
        key_ok = 1'b0; // R6
      end
    end
  end
  assign unlock_hit  = trigger_ff && key_ok; // R6
  assign trig_expire = trigger_ff && (unl_cnt_ff == '0); // R4

  // Start requests; the engine runs one process at a time and drops starts while busy.
  assign start_prog  = wr_op && avs_writedata[FIAP_PROG_BIT] && (eng_ff == ENG_IDLE)
                       && unlocked_ff
                       && (mode_ff == FIAP_MODE_WRITE || mode_ff == FIAP_MODE_ERASE); // R8 R3
  assign start_read  = wr_op && avs_writedata[FIAP_READ_BIT] && (eng_ff == ENG_IDLE)
                       && permit_ff && (mode_ff == FIAP_MODE_READ)
                       && !avs_writedata[FIAP_PROG_BIT]; // R10 R11 R12
  assign start_clear = wr_aux && avs_writedata[FIAP_AUX_CLEAR_BIT]
                       && (eng_ff == ENG_IDLE); // R13
  assign eng_end     = (eng_ff != ENG_IDLE) && (eng_cnt_ff == '0);

  always_comb begin
    nxt_eng = eng_ff;
    case (eng_ff)
      ENG_IDLE: begin
        if (start_prog) begin
          nxt_eng = ENG_PROG;
        end else if (start_read) begin
          nxt_eng = ENG_READ;
        end else if (start_clear) begin
          nxt_eng = ENG_CLEAR;
        end
      end
      ENG_PROG, ENG_READ, ENG_CLEAR: begin
        if (eng_end) begin
          nxt_eng = ENG_IDLE; // R8 R11 R13
        end
      end
      default: nxt_eng = ENG_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      eng_ff <= ENG_IDLE;
    end else begin
      eng_ff <= nxt_eng;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      eng_cnt_ff <= '0;
    end else if (eng_ff == ENG_IDLE) begin
      if (start_prog) begin
        eng_cnt_ff <= FIAP_CNT_W'(PROG_CYCLES - 1);
      end else if (start_read) begin
        eng_cnt_ff <= FIAP_CNT_W'(READ_CYCLES - 1);
      end else if (start_clear) begin
        eng_cnt_ff <= FIAP_CNT_W'(CLEAR_CYCLES - 1);
      end
    end else if (eng_cnt_ff != '0) begin
      eng_cnt_ff <= eng_cnt_ff - 1'b1;
    end
  end

  // Launch strobes are one cycle wide, in the cycle after the start write.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flash_cmd_ff <= '0;
    end else begin
      flash_cmd_ff.write_go <= start_prog && (mode_ff == FIAP_MODE_WRITE);
      flash_cmd_ff.erase_go <= start_prog && (mode_ff == FIAP_MODE_ERASE);
      flash_cmd_ff.read_go  <= start_read;
      flash_cmd_ff.clear_go <= start_clear;
      flash_cmd_ff.mode     <= (wr_op) ? avs_writedata[FIAP_MODE_LSB +: 3] : mode_ff;
    end
  end
  assign flash_cmd = flash_cmd_ff;
  assign cpu_stall = (eng_ff == ENG_PROG) || (eng_ff == ENG_READ); // R9

  // Operation control storage.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_ff   <= FIAP_MODE_WRITE;
      permit_ff <= 1'b0;
    end else if (wr_op) begin
      mode_ff   <= avs_writedata[FIAP_MODE_LSB +: 3]; // R2
      permit_ff <= avs_writedata[FIAP_PERMIT_BIT]; // R10
    end
  end

  // Hardware set beats a software clear in the same cycle.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      unlocked_ff <= 1'b0;
    end else if (unlock_hit) begin
      unlocked_ff <= 1'b1; // R1 R6
    end else if (wr_op && !avs_writedata[FIAP_UNLOCKED_BIT]) begin
      unlocked_ff <= 1'b0; // R1
    end
  end
  assign erase_write_unlocked = unlocked_ff;

  // Unlock window. Retriggering while armed is ignored so the window cannot be stretched.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      trigger_ff <= 1'b0;
      unl_cnt_ff <= '0;
    end else if (!trigger_ff) begin
      if (wr_op && avs_writedata[FIAP_TRIGGER_BIT]
          && (avs_writedata[FIAP_MODE_LSB +: 3] == FIAP_MODE_UNLOCK)) begin
        trigger_ff <= 1'b1; // R2 R4
        unl_cnt_ff <= FIAP_CNT_W'(UNLOCK_CYCLES - 1); // R16
      end
    end else if (trig_expire) begin
      trigger_ff <= 1'b0; // R4 R7
    end else begin
      unl_cnt_ff <= unl_cnt_ff - 1'b1;
    end
  end

  // Data word registers; writes inside the window mark each key byte as seen.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < FIAP_DATA_REGS; i++) begin
        data_ff[i] <= 8'h00; // R15
      end
    end else begin
      for (int i = 0; i < FIAP_DATA_REGS; i++) begin
        if (avs_write && (word_idx == FIAP_OFF_DATA0[5:2] + 4'(i))) begin
          data_ff[i] <= avs_writedata[7:0]; // R15
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      written_ff <= '0;
    end else if (!trigger_ff) begin
      written_ff <= '0; // R16
    end else begin
      for (int i = 0; i < FIAP_DATA_REGS; i++) begin
        if (avs_write && (word_idx == FIAP_OFF_DATA0[5:2] + 4'(i))) begin
          written_ff[i] <= 1'b1;
        end
      end
    end
  end

  // Auxiliary control: bits 7 and 4 are plain storage, bit 0 reads the clear engine busy, the rest read zero.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      aux_r7_ff <= 1'b0;
      aux_r4_ff <= 1'b0;
    end else if (wr_aux) begin
      aux_r7_ff <= avs_writedata[FIAP_AUX_R7_BIT]; // R14
      aux_r4_ff <= avs_writedata[FIAP_AUX_R4_BIT]; // R14
    end
  end

  // Start bits read back from the engine, so they fall when each process ends.
  assign op_view  = {unlocked_ff, mode_ff, trigger_ff, eng_ff == ENG_PROG,
                     permit_ff, eng_ff == ENG_READ}; // R8 R11
  assign aux_view = {aux_r7_ff, 1'b0, 1'b0, aux_r4_ff, 3'h0, eng_ff == ENG_CLEAR}; // R13 R14

  // Interrupts: a failed window is one that expires while the flag is clear and no key matches.
  always_comb begin
    irq_events = '0;
    irq_events[FIAP_IRQ_UNLOCK_OK]   = unlock_hit && !unlocked_ff;
    irq_events[FIAP_IRQ_UNLOCK_FAIL] = trig_expire && !unlocked_ff && !unlock_hit; // R7
    irq_events[FIAP_IRQ_PROG_DONE]   = eng_end && (eng_ff == ENG_PROG);
    irq_events[FIAP_IRQ_READ_DONE]   = eng_end && (eng_ff == ENG_READ);
    irq_events[FIAP_IRQ_CLEAR_DONE]  = eng_end && (eng_ff == ENG_CLEAR);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_ff <= '0;
    end else if (rd_stat_done) begin
      irq_stat_ff <= irq_events;
    end else begin
      irq_stat_ff <= irq_stat_ff | irq_events;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_mask_ff <= '0;
    end else if (avs_write && (word_idx == FIAP_OFF_IRQ_MASK[5:2])) begin
      irq_mask_ff <= avs_writedata[FIAP_IRQ_W-1:0];
    end
  end
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // Read path. Unmapped words read zero and ignore writes.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_done_ff  <= 1'b0;
      readdata_ff <= '0;
    end else begin
      rd_done_ff <= rd_first;
      if (rd_first) begin
        readdata_ff <= '0;
        if (word_idx == FIAP_OFF_OP_CTRL[5:2]) begin
          readdata_ff[7:0] <= op_view;
        end else if (word_idx == FIAP_OFF_AUX_CTRL[5:2]) begin
          readdata_ff[7:0] <= aux_view;
        end else if (word_idx == FIAP_OFF_IRQ_STAT[5:2]) begin
          readdata_ff[FIAP_IRQ_W-1:0] <= irq_stat_ff;
        end else if (word_idx == FIAP_OFF_IRQ_MASK[5:2]) begin
          readdata_ff[FIAP_IRQ_W-1:0] <= irq_mask_ff;
        end else begin
          for (int i = 0; i < FIAP_DATA_REGS; i++) begin
            if (word_idx == FIAP_OFF_DATA0[5:2] + 4'(i)) begin
              readdata_ff[7:0] <= data_ff[i]; // R15
            end
          end
        end
      end
    end
  end

  default clocking fiap_cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_unlock_needs_key: assert property ($rose(unlocked_ff) |-> $past(unlock_hit)) // R6
    else $error("unlocked flag rose without a matching key");
  a_sw_set_ignored: assert property ( // R1
    wr_op && avs_writedata[FIAP_UNLOCKED_BIT] && !unlocked_ff && !unlock_hit
    |=> !unlocked_ff)
    else $error("software write of one set the unlocked flag");
  a_sw_clear_works: assert property ( // R1
    wr_op && !avs_writedata[FIAP_UNLOCKED_BIT] && !unlock_hit |=> !unlocked_ff)
    else $error("software write of zero left the flag set");
  a_trigger_mode_unlock: assert property ($rose(trigger_ff) |-> $past(wr_op) // R2
    && ($past(avs_writedata[FIAP_MODE_LSB +: 3]) == FIAP_MODE_UNLOCK))
    else $error("trigger armed outside unlock mode");
  // A new window may be armed right after expiry, so only the falling edge is checked.
  a_trigger_expiry: assert property (trig_expire |=> !trigger_ff // R4
    && !op_view[FIAP_TRIGGER_BIT])
    else $error("trigger not cleared at timer expiry");
  // A flag cleared by software or set by the key in the expiry cycle is no failure.
  a_key_fail_locked: assert property ($fell(trigger_ff) && !unlocked_ff // R7
    && !$past(unlocked_ff) |-> irq_stat_ff[FIAP_IRQ_UNLOCK_FAIL])
    else $error("failed window not reported");
  a_prog_needs_flag: assert property ($rose(eng_ff == ENG_PROG) |-> $past(unlocked_ff)) // R8
    else $error("program started while locked");
  a_stall_covers_busy: assert property ($rose(eng_ff == ENG_READ) |-> cpu_stall [*2] // R9
    or (cpu_stall ##1 !cpu_stall))
    else $error("cpu not stalled during read");
  a_read_permit: assert property ($rose(eng_ff == ENG_READ) |-> $past(permit_ff)) // R10
    else $error("read ran without permit");
  a_read_finishes: assert property (eng_end && eng_ff == ENG_READ // R11
    |=> !op_view[FIAP_READ_BIT] && irq_stat_ff[FIAP_IRQ_READ_DONE])
    else $error("read start bit not cleared on completion");
  a_clear_finishes: assert property (eng_end && eng_ff == ENG_CLEAR // R13
    |=> !aux_view[FIAP_AUX_CLEAR_BIT])
    else $error("buffer clear bit not cleared");
  a_aux_reads_zero: assert property (avs_read && !avs_waitrequest // R14
    && word_idx == FIAP_OFF_AUX_CTRL[5:2]
    |-> avs_readdata[6:5] == 2'h0 && avs_readdata[3:1] == 3'h0)
    else $error("aux reserved bits read nonzero");
  a_data_stores: assert property (avs_write && word_idx == FIAP_OFF_DATA0[5:2] + 4'h2 // R15
    |=> data_ff[2] == $past(avs_writedata[7:0]))
    else $error("data register did not store write");

  c_unlock_ok: cover property ($rose(unlocked_ff));
  c_prog_done: cover property (eng_end && eng_ff == ENG_PROG);
  c_read_done: cover property (eng_end && eng_ff == ENG_READ);
  c_unlock_fail: cover property ($fell(trigger_ff) && !unlocked_ff);

endmodule : fiap_ctrl

// File: fiap_ctrl_test.sv
// Self-checking testbench for the flash IAP control register block.
module fiap_ctrl_test
  import fiap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Shortened unlock, program and clear lengths keep the run brief; read keeps its default; every expectation derives from these.
  localparam int UL_C = 16;
  localparam int PG_C = 8;
  localparam int RD_C = 4;
  localparam int CL_C = 8;

  logic           core_clk;
  logic           nrst;
  logic [5:0]     avs_address;
  logic           avs_read;
  logic           avs_write;
  logic [31:0]    avs_writedata;
  logic [31:0]    avs_readdata;
  logic           avs_waitrequest;
  fiap_flash_type flash_cmd;
  logic           erase_write_unlocked;
  logic           cpu_stall;
  logic           irq;
  int             n_errors;
  int             checks_done;
  logic [31:0]    seed;
  logic [31:0]    rdv;
  logic [4:0]     mask_v;

  fiap_ctrl #(
    .UNLOCK_CYCLES(UL_C),
    .PROG_CYCLES  (PG_C),
    .READ_CYCLES  (RD_C),
    .CLEAR_CYCLES (CL_C)
  ) fiap_ctrl_inst (
    .core_clk            (core_clk),
    .nrst                (nrst),
    .avs_address         (avs_address),
    .avs_read            (avs_read),
    .avs_write           (avs_write),
    .avs_writedata       (avs_writedata),
    .avs_readdata        (avs_readdata),
    .avs_waitrequest     (avs_waitrequest),
    .flash_cmd           (flash_cmd),
    .erase_write_unlocked(erase_write_unlocked),
    .cpu_stall           (cpu_stall),
    .irq                 (irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // One bus transfer; the request stands until waitrequest is seen low at an edge.
  task automatic xfer(input bit is_rd, input logic [5:0] a, input logic [7:0] d);
    int k;
    @(posedge core_clk);
    avs_read      <= is_rd;
    avs_write     <= !is_rd;
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    for (k = 0; k < 20; k++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      n_errors++;
      $display("[ERR] %0t bus answer never came", $time);
      print_verdict();
    end else begin
      rdv = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask : xfer

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    xfer(1'b0, a, d);
  endtask : wr

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e, input string what);
    xfer(1'b1, a, 8'h00);
    chk(rdv, {24'h0, e}, what);
  endtask : rd_chk

  // Writes a start, then checks launch strobes and the length of the stall.
  task automatic run_go(input logic [5:0] a, input logic [7:0] v, input logic [3:0] go,
                        input int len);
    int n;
    wr(a, v);
    @(posedge core_clk);
    chk({28'h0, flash_cmd.write_go, flash_cmd.erase_go, flash_cmd.read_go,
         flash_cmd.clear_go}, {28'h0, go}, "launch strobes");
    n = 0;
    while (cpu_stall === 1'b1 && n < 200) begin
      n++;
      @(posedge core_clk);
    end
    if (n == 200) begin
      n_errors++;
      $display("[ERR] %0t stall never ended", $time);
      print_verdict();
    end else begin
      chk(n, len, "stall length");
    end
  endtask : run_go

  task automatic st(input logic [4:0] e);
    chk({31'h0, irq}, {31'h0, |(e & mask_v)}, "irq level");
    rd_chk(FIAP_OFF_IRQ_STAT, {3'h0, e}, "irq status");
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0, "irq after status read");
  endtask : st

  task automatic do_unlock(input int bad, input bit late, input bit ok);
    wr(FIAP_OFF_OP_CTRL, 8'h60);
    wr(FIAP_OFF_OP_CTRL, 8'h68);
    if (late) begin
      rd_chk(FIAP_OFF_OP_CTRL, 8'h68, "trigger armed");
      repeat (UL_C) @(posedge core_clk);
    end
    for (int i = 0; i < FIAP_DATA_REGS; i++) begin
      wr(FIAP_OFF_DATA0 + 6'(4 * i), FIAP_KEY[i] ^ {7'h0, i == bad});
    end
    // The flag rises at the edge after the last key write, so look one edge later.
    repeat (2) @(posedge core_clk);
    chk({31'h0, erase_write_unlocked}, {31'h0, ok}, "unlocked flag");
    repeat (UL_C) @(posedge core_clk);
    rd_chk(FIAP_OFF_OP_CTRL, {ok, 7'h60}, "trigger cleared by timer");
    st(ok ? 5'h01 : 5'h02);
  endtask : do_unlock

  initial begin
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    n_errors = 0;
    checks_done = 0;
    seed = 32'd20;
    mask_v = 5'h00;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    // Every register resets to zero; the word past the map reads zero too.
    for (int a = 0; a <= 8'h28; a += 4) begin
      rd_chk(6'(a), 8'h00, "reset value");
    end
    $display("test reset_values done");
    // Software keeps bits 7 and 4 at zero; every other unused bit is written one.
    run_go(FIAP_OFF_AUX_CTRL, 8'h6f, 4'b0001, 0);
    rd_chk(FIAP_OFF_AUX_CTRL, 8'h01, "aux while clearing");
    repeat (CL_C) @(posedge core_clk);
    rd_chk(FIAP_OFF_AUX_CTRL, 8'h00, "aux after clear");
    st(5'h10);
    wr(FIAP_OFF_AUX_CTRL, 8'h00);
    $display("test aux_clear done");
    wr(FIAP_OFF_OP_CTRL, 8'h80);
    rd_chk(FIAP_OFF_OP_CTRL, 8'h00, "software cannot set flag");
    run_go(FIAP_OFF_OP_CTRL, 8'h04, 4'b0000, 0);
    do_unlock(2, 1'b0, 1'b0);
    wr(FIAP_OFF_IRQ_MASK, 8'h1f);
    mask_v = 5'h1f;
    rd_chk(FIAP_OFF_IRQ_MASK, 8'h1f, "mask readback");
    do_unlock(6, 1'b1, 1'b0);
    do_unlock(6, 1'b0, 1'b1);
    $display("test unlock done");
    for (int m = 0; m < 8; m++) begin
      wr(FIAP_OFF_OP_CTRL, {1'b1, 3'(m), 4'h0});
      repeat (2) @(posedge core_clk);
      chk({29'h0, flash_cmd.mode}, m, "mode copy");
      run_go(FIAP_OFF_OP_CTRL, {1'b1, 3'(m), 4'h4}, m == 0 ? 4'b1000 : m == 1 ? 4'b0100 :
             4'b0000, m <= 1 ? PG_C : 0);
      if (m <= 1) begin
        st(5'h04);
        rd_chk(FIAP_OFF_OP_CTRL, {1'b1, 3'(m), 4'h0}, "program bit cleared");
      end
    end
    $display("test modes done");
    run_go(FIAP_OFF_OP_CTRL, 8'hb0, 4'b0000, 0);
    run_go(FIAP_OFF_OP_CTRL, 8'hb1, 4'b0000, 0);
    wr(FIAP_OFF_OP_CTRL, 8'hb2);
    run_go(FIAP_OFF_OP_CTRL, 8'hb3, 4'b0010, RD_C);
    st(5'h08);
    rd_chk(FIAP_OFF_OP_CTRL, 8'hb2, "read bit cleared");
    $display("test flash_read done");
    for (int i = 0; i < FIAP_DATA_REGS; i++) begin
      rdv = xs();
      wr(FIAP_OFF_DATA0 + 6'(4 * i), rdv[7:0]);
      rd_chk(FIAP_OFF_DATA0 + 6'(4 * i), seed[7:0], "data word");
    end
    $display("test data_words done");
    wr(FIAP_OFF_OP_CTRL, 8'h00);
    @(posedge core_clk);
    chk({31'h0, erase_write_unlocked}, 32'h0, "flag cleared by software");
    run_go(FIAP_OFF_OP_CTRL, 8'h04, 4'b0000, 0);
    $display("test disable done");
    print_verdict();
  end

endmodule : fiap_ctrl_test
